/* File: include/drps_defs.svh */
// Constants for the run-permit, sleep and wake sequencer
`ifndef DRPS_DEFS_SVH
`define DRPS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DRPS_OFS_CTRL        8'h00
`define DRPS_OFS_WAKE        8'h04
`define DRPS_OFS_RWAIT       8'h08
`define DRPS_OFS_STAT        8'h0C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DRPS_CTRL_PROT_BIT   0
`define DRPS_CTRL_LFA_LO     1
`define DRPS_CTRL_LFA_HI     2
`define DRPS_CTRL_PLR_BIT    3
`define DRPS_CTRL_SRC_BIT    4
`define DRPS_CTRL_SOFT_BIT   5
`define DRPS_CTRL_W          6
`define DRPS_CTRL_RST        6'h10

// ----------------------------------------------------------------
// Low-frequency action codes
// ----------------------------------------------------------------
`define DRPS_LFA_HOLD        2'h0
`define DRPS_LFA_STOP        2'h1
`define DRPS_LFA_SLEEP       2'h2

// ----------------------------------------------------------------
// Time settings, in tenths of a second
// ----------------------------------------------------------------
`define DRPS_TIME_W          16
`define DRPS_TIME_MAX        16'h8CA0
`define DRPS_WAKE_RST        16'h0000
`define DRPS_RWAIT_RST       16'h000A

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define DRPS_CLK_PERIOD_NS   5
`define DRPS_TICK_TIME_NS    100000000
`define DRPS_DIV_W           25

`endif

/* File: include/drps_pkg.sv */
// Types for the run-permit, sleep and wake sequencer
package drps_pkg;

    typedef enum logic [7:0] {
        DRPS_INIT    = 8'h01,
        DRPS_PROTECT = 8'h02,
        DRPS_STOP    = 8'h04,
        DRPS_RUN     = 8'h08,
        DRPS_SLEEP   = 8'h10,
        DRPS_PLOSS   = 8'h20,
        DRPS_RWAIT   = 8'h40
    } drps_state_t;

endpackage

/* File: rtl/drps_seq.sv */
// Run-permit, low-frequency sleep/wake and power-loss restart sequencer
// Function
// - After power-up the run terminal is sampled automatically before any run is allowed.
// - With power_on_run_terminal_protection at 0 an active terminal at power-up locks out running until it drops and rises again.
// - With power_on_run_terminal_protection at 1 an active terminal at power-up starts the drive once initialization ends.
// - Below the lower limit, low_freq_action_select 0 holds at the limit, 1 stops and 2 sleeps.
// - Entering sleep coasts the drive with no controlled ramp.
// - Sleep wakes to run only after the set frequency stays above the limit for the full wake_delay, or at once if low_freq_action_select leaves 2.
// - wake_delay spans 0.0 to 3600.0 s in 0.1 s steps, resets to 0 and matters only in sleep mode.
// - power_loss_restart_enable exists and resets to 0.
// - At 0 no restart follows a power loss; at 1 the drive runs after restart_wait_time if start conditions hold.
// - restart_wait_time spans 0.0 to 3600.0 s in 0.1 s steps, resets to 1.0 s and matters only when restart is enabled.
// - The power-up terminal check applies only when the run source is the terminals.
`timescale 1ns/10ps
`include "drps_defs.svh"

module drps_seq
    import drps_pkg::*;
#(
    parameter int TICK_CYCLES = `DRPS_TICK_TIME_NS / `DRPS_CLK_PERIOD_NS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        run_term_i,
    input  wire logic        below_low_i,
    input  wire logic        power_lost_i,
    input  wire logic        init_done_i,
    output logic             run_req_o,
    output logic             coast_o,
    output logic             hold_low_o
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic       term_s;
    logic       below_s;
    logic       lost_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else begin
            meta_r <= {power_lost_i, below_low_i, run_term_i};
            sync_r <= meta_r;
        end
    end

    assign term_s  = sync_r[0];
    assign below_s = sync_r[1];
    assign lost_s  = sync_r[2];

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [`DRPS_CTRL_W-1:0] ctrl_r;
    logic [`DRPS_TIME_W-1:0] wake_r;
    logic [`DRPS_TIME_W-1:0] rwait_r;
    logic                    ack_r;
    logic [31:0]             rdat_r;
    drps_state_t             state_r;
    drps_state_t             state_nxt;

    logic                    prot_en;
    logic [1:0]              lfa_sel;
    logic                    plr_en;
    logic                    src_term;
    logic                    soft_run;
    logic                    bus_req;
    logic                    wr_en;
    logic                    hit_ctrl;
    logic                    hit_wake;
    logic                    hit_rwait;
    logic                    hit_stat;
    logic [15:0]             wr_half;
    logic [`DRPS_TIME_W-1:0] wr_time;
    logic [31:0]             rd_mux;

    assign prot_en   = ctrl_r[`DRPS_CTRL_PROT_BIT];
    assign lfa_sel   = ctrl_r[`DRPS_CTRL_LFA_HI:`DRPS_CTRL_LFA_LO];
    assign plr_en    = ctrl_r[`DRPS_CTRL_PLR_BIT];
    assign src_term  = ctrl_r[`DRPS_CTRL_SRC_BIT];
    assign soft_run  = ctrl_r[`DRPS_CTRL_SOFT_BIT];

    assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
    // Write commits on the edge the master samples ack, not a cycle early
    assign wr_en     = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign hit_ctrl  = (wb_adr_i == `DRPS_OFS_CTRL);
    assign hit_wake  = (wb_adr_i == `DRPS_OFS_WAKE);
    assign hit_rwait = (wb_adr_i == `DRPS_OFS_RWAIT);
    assign hit_stat  = (wb_adr_i == `DRPS_OFS_STAT);

    // Byte lanes merged into the low half-word of a time setting
    assign wr_half[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0]  : (hit_wake ? wake_r[7:0]  : rwait_r[7:0]);
    assign wr_half[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : (hit_wake ? wake_r[15:8] : rwait_r[15:8]);
    // Out-of-range settings saturate at one hour
    assign wr_time = (wr_half > `DRPS_TIME_MAX) ? `DRPS_TIME_MAX : wr_half;

    assign rd_mux = hit_ctrl  ? {26'h000_0000, ctrl_r} :
                    hit_wake  ? {16'h0000, wake_r} :
                    hit_rwait ? {16'h0000, rwait_r} :
                    hit_stat  ? {21'h00_0000, below_s, term_s, lost_s, state_r} :
                    32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `DRPS_CTRL_RST;
        end else if (wr_en && hit_ctrl && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[`DRPS_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_r  <= `DRPS_WAKE_RST;
            rwait_r <= `DRPS_RWAIT_RST;
        end else if (wr_en && hit_wake) begin
            wake_r  <= wr_time;
        end else if (wr_en && hit_rwait) begin
            rwait_r <= wr_time;
        end
    end

    // Unmapped addresses still ack, reading zero, so a stray access never hangs the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= bus_req;
            rdat_r <= bus_req ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ----------------------------------------------------------------
    // Tenth-second timebase and interval counter
    // ----------------------------------------------------------------
    // One shared timer; sleep and restart waits never overlap. Clearing
    // the prescaler too keeps each interval whole, not a partial tick.
    logic [`DRPS_DIV_W-1:0]  div_r;
    logic [`DRPS_TIME_W-1:0] tcnt_r;
    logic                    tick;
    logic                    tmr_clr;
    logic                    wake_done;
    logic                    rwait_done;

    assign tick = (div_r == `DRPS_DIV_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || tmr_clr) begin
            div_r  <= '0;
            tcnt_r <= '0;
        end else if (tick) begin
            div_r  <= '0;
            tcnt_r <= (tcnt_r == `DRPS_TIME_MAX) ? tcnt_r : tcnt_r + 16'h0001;
        end else begin
            div_r  <= div_r + `DRPS_DIV_W'(1);
        end
    end

    assign wake_done  = (tcnt_r >= wake_r);
    assign rwait_done = (tcnt_r >= rwait_r);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    logic run_cmd;
    logic term_src_active;
    logic sleep_hit;

    // Software run bit stands in when the terminals are not the source
    assign run_cmd         = src_term ? term_s : soft_run;
    assign term_src_active = src_term & term_s;
    assign sleep_hit       = below_s & (lfa_sel == `DRPS_LFA_SLEEP);

    always_comb begin
        state_nxt = state_r;
        tmr_clr   = 1'b0;
        case (state_r)
            DRPS_INIT: begin
                // Synchronisers have settled by the time init completes
                if (init_done_i) begin
                    if (term_src_active && !prot_en) begin
                        state_nxt = DRPS_PROTECT;
                    end else if (run_cmd) begin
                        state_nxt = DRPS_RUN;
                    end else begin
                        state_nxt = DRPS_STOP;
                    end
                end
            end
            DRPS_PROTECT: begin
                if (lost_s) begin
                    state_nxt = DRPS_PLOSS;
                end else if (!run_cmd) begin
                    state_nxt = DRPS_STOP;
                end
            end
            DRPS_STOP: begin
                if (lost_s) begin
                    state_nxt = DRPS_PLOSS;
                end else if (run_cmd) begin
                    state_nxt = DRPS_RUN;
                end
            end
            DRPS_RUN: begin
                tmr_clr = 1'b1;
                if (lost_s) begin
                    state_nxt = DRPS_PLOSS;
                end else if (!run_cmd) begin
                    state_nxt = DRPS_STOP;
                end else if (sleep_hit) begin
                    state_nxt = DRPS_SLEEP;
                end
            end
            DRPS_SLEEP: begin
                if (below_s) begin
                    tmr_clr = 1'b1;
                end
                if (lost_s) begin
                    state_nxt = DRPS_PLOSS;
                end else if (!run_cmd) begin
                    state_nxt = DRPS_STOP;
                end else if (lfa_sel != `DRPS_LFA_SLEEP) begin
                    state_nxt = DRPS_RUN;
                end else if (!below_s && wake_done) begin
                    state_nxt = DRPS_RUN;
                end
            end
            DRPS_PLOSS: begin
                tmr_clr = 1'b1;
                if (!lost_s) begin
                    if (plr_en) begin
                        state_nxt = DRPS_RWAIT;
                    end else if (run_cmd) begin
                        // No self restart: command must be withdrawn and reissued
                        state_nxt = DRPS_PROTECT;
                    end else begin
                        state_nxt = DRPS_STOP;
                    end
                end
            end
            DRPS_RWAIT: begin
                if (lost_s) begin
                    state_nxt = DRPS_PLOSS;
                end else if (!plr_en) begin
                    state_nxt = run_cmd ? DRPS_PROTECT : DRPS_STOP;
                end else if (rwait_done) begin
                    state_nxt = run_cmd ? DRPS_RUN : DRPS_STOP;
                end
            end
            default: begin
                state_nxt = DRPS_INIT;
                tmr_clr   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= DRPS_INIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Drive requests
    // ----------------------------------------------------------------
    logic run_nxt;
    logic coast_nxt;
    logic hold_nxt;
    logic run_r;
    logic coast_r;
    logic hold_r;

    // Stop mode withholds run while below the limit, resumes once above
    assign run_nxt   = (state_nxt == DRPS_RUN) &
                       ~(below_s & (lfa_sel == `DRPS_LFA_STOP));
    assign coast_nxt = (state_nxt == DRPS_SLEEP) | (state_nxt == DRPS_PLOSS);
    assign hold_nxt  = (state_nxt == DRPS_RUN) & below_s &
                       (lfa_sel != `DRPS_LFA_STOP) & (lfa_sel != `DRPS_LFA_SLEEP);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r   <= 1'b0;
            coast_r <= 1'b0;
            hold_r  <= 1'b0;
        end else begin
            run_r   <= run_nxt;
            coast_r <= coast_nxt;
            hold_r  <= hold_nxt;
        end
    end

    assign run_req_o  = run_r;
    assign coast_o    = coast_r;
    assign hold_low_o = hold_r;

endmodule // drps_seq

/* File: tb/drps_seq_monitor.sv */
// Port-level concurrent checks for the run-permit sequencer
`timescale 1ns/10ps
module drps_seq_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        run_term_i,
    input wire logic        below_low_i,
    input wire logic        power_lost_i,
    input wire logic        init_done_i,
    input wire logic        run_req_o,
    input wire logic        coast_o,
    input wire logic        hold_low_o
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    // Reset must not be masked by the default disable here
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !run_req_o && !coast_o && !hold_low_o)
        else $error("outputs active after reset edge");
    a_no_early_run: assert property (!init_done_i |-> !run_req_o)
        else $error("run before initialization");
    a_coast_no_run: assert property (coast_o |-> !run_req_o)
        else $error("coast and run together");
    a_hold_is_run: assert property (hold_low_o |-> run_req_o)
        else $error("hold at limit without run");
    a_coast_cause: assert property ($rose(coast_o) |->
        ($past(below_low_i, 3) || $past(below_low_i, 4) || $past(power_lost_i, 3) || $past(power_lost_i, 4)))
        else $error("coast without low frequency or power loss");
endmodule // drps_seq_monitor

/* File: tb/drps_term_src.sv */
// Behavioural run terminal, frequency comparator and supply source
`timescale 1ns/10ps
module drps_term_src (
    input  wire logic clk_i,
    input  wire logic run_cmd_i,
    input  wire logic below_cmd_i,
    input  wire logic lost_cmd_i,
    output logic      run_term_o   = 1'b0,
    output logic      below_low_o  = 1'b0,
    output logic      power_lost_o = 1'b0
);
    // ----------------------------------------------------------------
    // Pins are registered and move on the rising edge, one cycle after their command
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        run_term_o   <= run_cmd_i;
        below_low_o  <= below_cmd_i;
        power_lost_o <= lost_cmd_i;
    end
endmodule // drps_term_src

/* File: tb/tb_top.sv */
// Self-checking bench for the run-permit sequencer
`timescale 1ns/10ps
`include "drps_defs.svh"
module tb_top;
    localparam int TICKS = 4;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] dat = 0, q, wb_dat_o;
    logic        run_cmd = 0, below_cmd = 0, lost_cmd = 0, init_done = 0;
    logic        wb_ack_o, run_term, below_low, power_lost, run_req_o, coast_o, hold_low_o;
    int          n_fail = 0, total_checks = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;

    drps_term_src i_drps_term_src (.clk_i(clk_i), .run_cmd_i(run_cmd), .below_cmd_i(below_cmd),
        .lost_cmd_i(lost_cmd), .run_term_o(run_term), .below_low_o(below_low), .power_lost_o(power_lost));
    drps_seq #(.TICK_CYCLES(TICKS)) i_drps_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .run_term_i(run_term), .below_low_i(below_low), .power_lost_i(power_lost), .init_done_i(init_done),
        .run_req_o(run_req_o), .coast_o(coast_o), .hold_low_o(hold_low_o));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task tally_and_finish;
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic single cycle, waits for ack with no bound of its own
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ack_latency", 32'h0000_0002, 32'(n));
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    task pins(input logic [2:0] e, input string nm);
        chk(nm, 32'(e), 32'({run_req_o, coast_o, hold_low_o}));
    endtask
    // Init completes only after the control word is in place
    task boot(input logic [31:0] ctrl, input logic term);
        rst_i <= 1'b1;
        init_done <= 1'b0;
        lost_cmd <= 1'b0;
        below_cmd <= 1'b0;
        run_cmd <= term;
        wt(8);
        rst_i <= 1'b0;
        xfer(`DRPS_OFS_CTRL, 1'b1, ctrl);
        wt(3);
        init_done <= 1'b1;
        wt(8);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        wt(8);
        rst_i <= 1'b0;
        rd(`DRPS_OFS_CTRL, 32'h0000_0010, "ctrl");
        rd(`DRPS_OFS_WAKE, 32'h0000_0000, "wake");
        rd(`DRPS_OFS_RWAIT, 32'h0000_000A, "rwait");
        rd(8'h10, 32'h0000_0000, "unmapped");
        rd(`DRPS_OFS_STAT, 32'h0000_0001, "stat");
        xfer(`DRPS_OFS_WAKE, 1'b1, 32'h0000_FFFF);
        rd(`DRPS_OFS_WAKE, 32'h0000_8CA0, "wake");
        xfer(`DRPS_OFS_RWAIT, 1'b1, 32'h0000_FFFF);
        rd(`DRPS_OFS_RWAIT, 32'h0000_8CA0, "rwait");
        boot(32'h0000_0010, 1'b1);
        pins(3'b000, "protect");
        rd(`DRPS_OFS_STAT, 32'h0000_0202, "stat");
        run_cmd <= 1'b0;
        wt(8);
        run_cmd <= 1'b1;
        wt(8);
        pins(3'b100, "rearm");
        below_cmd <= 1'b1;
        wt(8);
        pins(3'b101, "hold");
        xfer(`DRPS_OFS_CTRL, 1'b1, 32'h0000_0012);
        wt(8);
        pins(3'b000, "stop");
        below_cmd <= 1'b0;
        wt(8);
        pins(3'b100, "resume");
        xfer(`DRPS_OFS_WAKE, 1'b1, 32'h0000_0003);
        xfer(`DRPS_OFS_CTRL, 1'b1, 32'h0000_0014);
        below_cmd <= 1'b1;
        wt(8);
        pins(3'b010, "sleep");
        below_cmd <= 1'b0;
        wt(8);
        pins(3'b010, "early");
        below_cmd <= 1'b1;
        wt(3);
        below_cmd <= 1'b0;
        wt(10);
        pins(3'b010, "restart");
        wt(20);
        pins(3'b100, "wake");
        xfer(`DRPS_OFS_CTRL, 1'b1, 32'h0000_0010);
        lost_cmd <= 1'b1;
        wt(8);
        pins(3'b010, "loss");
        lost_cmd <= 1'b0;
        wt(30);
        pins(3'b000, "no_restart");
        run_cmd <= 1'b0;
        wt(8);
        run_cmd <= 1'b1;
        wt(8);
        xfer(`DRPS_OFS_RWAIT, 1'b1, 32'h0000_0002);
        xfer(`DRPS_OFS_CTRL, 1'b1, 32'h0000_0018);
        lost_cmd <= 1'b1;
        wt(8);
        lost_cmd <= 1'b0;
        wt(7);
        chk("rwait_run", 32'h0000_0000, 32'(run_req_o));
        wt(20);
        chk("auto_run", 32'h0000_0001, 32'(run_req_o));
        boot(32'h0000_0011, 1'b1);
        pins(3'b100, "auto_start");
        boot(32'h0000_0000, 1'b1);
        rd(`DRPS_OFS_STAT, 32'h0000_0204, "stat");
        xfer(`DRPS_OFS_CTRL, 1'b1, 32'h0000_0020);
        wt(8);
        chk("soft_run", 32'h0000_0001, 32'(run_req_o));
        tally_and_finish();
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
endmodule // tb_top

bind drps_seq drps_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_drps_seq_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_term_i(run_term_i),
    .below_low_i(below_low_i), .power_lost_i(power_lost_i), .init_done_i(init_done_i),
    .run_req_o(run_req_o), .coast_o(coast_o), .hold_low_o(hold_low_o));
